// ---- dpt_pkg.sv ----
// dual phase pwm timer: shared constants, types and register map
// assumes a plain register port with 16-bit data, read data one cycle late
package dpt_pkg;
    // ==========================================================
    // register offsets (word index on the plain port)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_HIGH = 4'h1;
    localparam logic [3:0] ADDR_LOW = 4'h2;
    localparam logic [3:0] ADDR_INTV = 4'h3;
    localparam logic [3:0] ADDR_CLKCFG = 4'h4;
    localparam logic [3:0] ADDR_FRZ_SET = 4'h5;
    localparam logic [3:0] ADDR_FRZ_CLR = 4'h6;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h7;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'h9;
    // ==========================================================
    // control field positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_SRC = 1;
    localparam int CTRL_PRESC = 2;
    localparam int CTRL_CLKOUT = 3;
    localparam int CLKCFG_GATE = 0;
    localparam int CLKCFG_DIV_LO = 1;
    localparam logic [15:0] RESET_VALUE = 16'h0000;
    // ==========================================================
    // timing
    localparam int MCLK_HZ = 20000000;
    localparam int SLOW_HZ = 32768;
    localparam int FAST_BASE_HZ = 16000000;
    localparam int PRESCALE_FACTOR = 10;
    localparam int ACC_W = 26;
    // ==========================================================
    // types
    typedef enum logic {DPT_PH_HIGH, DPT_PH_LOW} dpt_phase_t;
    typedef struct packed {
        logic run;
        logic src_fast;
        logic prescale;
        logic clkout;
        logic gate;
        logic [1:0] div;
    } dpt_cfg_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } dpt_bus_t;
endpackage

// ---- dpt_tick_gen.sv ----
// timer clock tick generator: fractional accumulator on mclk
// assumes mclk at 20 MHz; ticks are one-cycle enables, never a clock
`timescale 1ns/100ps
module dpt_tick_gen #(
    parameter int ACC_W = dpt_pkg::ACC_W
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic active,
    input wire logic src_fast,
    input wire logic gate,
    input wire logic [1:0] div,
    output logic tick
);
    logic [ACC_W-1:0] acc;
    logic [ACC_W:0] sum;
    logic [ACC_W-1:0] inc;
    // fast rate 16 MHz shifted by divider; slow 32 kHz; fast gated off gives none
    assign inc = !src_fast ? ACC_W'(dpt_pkg::SLOW_HZ)
               : gate ? ACC_W'(dpt_pkg::FAST_BASE_HZ >> div) : '0;
    assign sum = {1'b0, acc} + {1'b0, inc};

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            acc <= '0;
            tick <= 1'b0;
        end else if (!active) begin
            acc <= '0;
            tick <= 1'b0;
        end else if (sum >= (ACC_W+1)'(dpt_pkg::MCLK_HZ)) begin
            acc <= ACC_W'(sum - (ACC_W+1)'(dpt_pkg::MCLK_HZ));
            tick <= 1'b1;
        end else begin
            acc <= ACC_W'(sum);
            tick <= 1'b0;
        end
    end
endmodule // dpt_tick_gen

// ---- dpt_prescale.sv ----
// divide-by-ten enable for the interval counter only
// assumes tick_in is a one-cycle enable
`timescale 1ns/100ps
module dpt_prescale #(
    parameter int FACTOR = dpt_pkg::PRESCALE_FACTOR
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic active,
    input wire logic enable,
    input wire logic tick_in,
    output logic tick_out
);
    logic [3:0] cnt;
    logic wrap;
    assign wrap = (cnt == 4'(FACTOR - 1));
    assign tick_out = enable ? (tick_in && wrap) : tick_in;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 4'h0;
        end else if (!active || !enable) begin
            cnt <= 4'h0;
        end else if (tick_in) begin
            cnt <= wrap ? 4'h0 : cnt + 4'h1;
        end
    end
endmodule // dpt_prescale

// ---- dpt_timer.sv ----
// dual phase pwm timer top: registers, pulse and interval counters, irq
// assumes synchronous inputs on mclk, single-cycle strobes, 16-bit data
//
// Overview of operation
// - counters and reload registers reset to zero
// - timer clock 16/8/4/2 MHz or 32 kHz
// - fast clocks need source select and gate
// - prescale divides interval counter by ten
// - run enable loads counters and raises tick
// - pulse counter alternates high and low shadows
// - true output high in high phase; inverted complement
// - clock-output mode toggles during high phase
// - interval counter holds zero until low-phase end
// - cycle end reloads counter and both shadows
// - new reloads only take effect at start or cycle end
// - start-up also raises a tick interrupt
// - disabled timer held reset, reloads kept
// - interval address reads live interval counter
// - phase reload addresses read live pulse counter
// - freeze set stops counters, freeze clear resumes
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module dpt_timer #(
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    output logic pulse_out_true,
    output logic pulse_out_inverted,
    output logic tick_interrupt
);
    // ==========================================================
    // register file
    dpt_pkg::dpt_cfg_t cfg;
    dpt_pkg::dpt_bus_t bus;
    logic [CNT_W-1:0] high_phase_reload;
    logic [CNT_W-1:0] low_phase_reload;
    logic [CNT_W-1:0] interval_reload;
    logic freeze_request;
    logic irq_stat;
    logic irq_mask;

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    function automatic logic hit_wr(input dpt_pkg::dpt_bus_t b, input logic [3:0] a);
        return b.wr && (b.addr == a);
    endfunction

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            high_phase_reload <= CNT_W'(dpt_pkg::RESET_VALUE);
            low_phase_reload <= CNT_W'(dpt_pkg::RESET_VALUE);
            interval_reload <= CNT_W'(dpt_pkg::RESET_VALUE);
        end else begin
            // reload registers kept while disabled
            if (hit_wr(bus, dpt_pkg::ADDR_HIGH)) high_phase_reload <= CNT_W'(bus.wdata);
            if (hit_wr(bus, dpt_pkg::ADDR_LOW)) low_phase_reload <= CNT_W'(bus.wdata);
            if (hit_wr(bus, dpt_pkg::ADDR_INTV)) interval_reload <= CNT_W'(bus.wdata);
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg <= '0;
        end else begin
            if (hit_wr(bus, dpt_pkg::ADDR_CTRL)) begin
                cfg.run <= bus.wdata[dpt_pkg::CTRL_RUN];
                cfg.src_fast <= bus.wdata[dpt_pkg::CTRL_SRC];
                cfg.prescale <= bus.wdata[dpt_pkg::CTRL_PRESC];
                cfg.clkout <= bus.wdata[dpt_pkg::CTRL_CLKOUT];
            end
            if (hit_wr(bus, dpt_pkg::ADDR_CLKCFG)) begin
                cfg.gate <= bus.wdata[dpt_pkg::CLKCFG_GATE];
                cfg.div <= bus.wdata[dpt_pkg::CLKCFG_DIV_LO +: 2];
            end
        end
    end

    // freeze: set address wins if both ever coincide (strobes are one at a time)
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            freeze_request <= 1'b0;
        end else if (hit_wr(bus, dpt_pkg::ADDR_FRZ_SET) && bus.wdata[0]) begin
            freeze_request <= 1'b1;
        end else if (hit_wr(bus, dpt_pkg::ADDR_FRZ_CLR) && bus.wdata[0]) begin
            freeze_request <= 1'b0;
        end
    end

    // ==========================================================
    // clock selection
    logic active;
    logic tick;
    logic pulse_tick;
    logic intv_tick;
    assign active = cfg.run;

    dpt_tick_gen u_tick (
        .mclk(mclk),
        .nrst(nrst),
        .active(active),
        .src_fast(cfg.src_fast),
        .gate(cfg.gate),
        .div(cfg.div),
        .tick(tick)
    );

    // freeze masks ticks so every counter holds its value
    assign pulse_tick = tick && !freeze_request;

    dpt_prescale u_presc (
        .mclk(mclk),
        .nrst(nrst),
        .active(active),
        .enable(cfg.prescale),
        .tick_in(pulse_tick),
        .tick_out(intv_tick)
    );

    // ==========================================================
    // counters
    logic [CNT_W-1:0] pulse_cnt;
    logic [CNT_W-1:0] intv_cnt;
    logic [CNT_W-1:0] high_shadow;
    logic [CNT_W-1:0] low_shadow;
    dpt_pkg::dpt_phase_t phase;
    logic started;
    logic clk_half;
    logic pulse_zero;
    logic intv_zero;
    logic cycle_end;
    logic start_evt;
    logic phase_flip;

    assign pulse_zero = (pulse_cnt == '0);
    assign intv_zero = (intv_cnt == '0);
    // cycle ends only with both counters at zero in low phase
    assign cycle_end = pulse_tick && pulse_zero && intv_zero && (phase == dpt_pkg::DPT_PH_LOW);
    assign phase_flip = pulse_tick && pulse_zero && !cycle_end;
    assign start_evt = active && !started;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pulse_cnt <= '0;
            intv_cnt <= '0;
            high_shadow <= '0;
            low_shadow <= '0;
            phase <= dpt_pkg::DPT_PH_HIGH;
            started <= 1'b0;
        end else if (!active) begin
            pulse_cnt <= '0;
            intv_cnt <= '0;
            high_shadow <= '0;
            low_shadow <= '0;
            phase <= dpt_pkg::DPT_PH_HIGH;
            started <= 1'b0;
        end else if (start_evt || cycle_end) begin
            pulse_cnt <= high_phase_reload;
            high_shadow <= high_phase_reload;
            low_shadow <= low_phase_reload;
            intv_cnt <= interval_reload;
            phase <= dpt_pkg::DPT_PH_HIGH;
            started <= 1'b1;
        end else begin
            if (phase_flip) begin
                // zero tick counts too, so a phase is reload plus one ticks
                pulse_cnt <= (phase == dpt_pkg::DPT_PH_HIGH) ? low_shadow : high_shadow;
                phase <= (phase == dpt_pkg::DPT_PH_HIGH) ? dpt_pkg::DPT_PH_LOW
                                                         : dpt_pkg::DPT_PH_HIGH;
            end else if (pulse_tick && !pulse_zero) begin
                pulse_cnt <= pulse_cnt - CNT_W'(1);
            end
            if (intv_tick && !intv_zero) begin
                intv_cnt <= intv_cnt - CNT_W'(1);
            end
        end
    end

    // ==========================================================
    // outputs
    logic next_true;
    assign next_true = (phase == dpt_pkg::DPT_PH_HIGH) && started
                       && (!cfg.clkout || clk_half);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            clk_half <= 1'b0;
            pulse_out_true <= 1'b0;
            pulse_out_inverted <= 1'b1;
        end else if (!active) begin
            clk_half <= 1'b0;
            pulse_out_true <= 1'b0;
            pulse_out_inverted <= 1'b1;
        end else begin
            // half the timer clock gives the 50 % duty square wave
            if (pulse_tick) clk_half <= !clk_half;
            pulse_out_true <= next_true;
            pulse_out_inverted <= !next_true;
        end
    end

    // ==========================================================
    // interrupt: sticky status, write one to clear, set wins
    logic tick_evt;
    assign tick_evt = start_evt || cycle_end;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_stat <= 1'b0;
            irq_mask <= 1'b0;
            tick_interrupt <= 1'b0;
        end else begin
            if (tick_evt) irq_stat <= 1'b1;
            else if (hit_wr(bus, dpt_pkg::ADDR_IRQ_STAT) && bus.wdata[0]) irq_stat <= 1'b0;
            if (hit_wr(bus, dpt_pkg::ADDR_IRQ_MASK)) irq_mask <= bus.wdata[0];
            tick_interrupt <= (irq_stat || tick_evt) && irq_mask;
        end
    end

    // ==========================================================
    // read path
    logic [15:0] rd_mux;
    assign rd_mux =
        (bus.addr == dpt_pkg::ADDR_CTRL) ? {12'h000, cfg.clkout, cfg.prescale, cfg.src_fast, cfg.run} :
        (bus.addr == dpt_pkg::ADDR_HIGH) ? 16'(pulse_cnt) :
        (bus.addr == dpt_pkg::ADDR_LOW) ? 16'(pulse_cnt) :
        (bus.addr == dpt_pkg::ADDR_INTV) ? 16'(intv_cnt) :
        (bus.addr == dpt_pkg::ADDR_CLKCFG) ? {13'h0000, cfg.div, cfg.gate} :
        (bus.addr == dpt_pkg::ADDR_FRZ_SET) ? {15'h0000, freeze_request} :
        (bus.addr == dpt_pkg::ADDR_IRQ_STAT) ? {15'h0000, irq_stat} :
        (bus.addr == dpt_pkg::ADDR_IRQ_MASK) ? {15'h0000, irq_mask} :
        (bus.addr == dpt_pkg::ADDR_STATUS) ? {14'h0000, started, phase == dpt_pkg::DPT_PH_HIGH} :
        16'h0000;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) rdata <= 16'h0000;
        else rdata <= bus.rd ? rd_mux : 16'h0000;
    end

    // ==========================================================
    // checks
    sequence s_low_end;
        pulse_tick && pulse_zero && intv_zero && phase == dpt_pkg::DPT_PH_LOW && active;
    endsequence

    property p_reset_zero;
        @(posedge mclk) $rose(nrst) |-> pulse_cnt == '0 && intv_cnt == '0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("counters not zero after reset");

    property p_start_load;
        @(posedge mclk) disable iff (!nrst)
            start_evt |=> pulse_cnt == $past(high_phase_reload) && intv_cnt == $past(interval_reload);
    endproperty
    a_start_load: assert property (p_start_load) else $error("start did not load counters");

    property p_flip;
        @(posedge mclk) disable iff (!nrst)
            (active && phase_flip && phase == dpt_pkg::DPT_PH_HIGH) |=>
                phase == dpt_pkg::DPT_PH_LOW && pulse_cnt == $past(low_shadow);
    endproperty
    a_flip: assert property (p_flip) else $error("phase did not alternate");

    property p_compl;
        @(posedge mclk) disable iff (!nrst) pulse_out_inverted == !pulse_out_true;
    endproperty
    a_compl: assert property (p_compl) else $error("outputs not complementary");

    property p_cycle_reload;
        @(posedge mclk) disable iff (!nrst)
            s_low_end |=> high_shadow == $past(high_phase_reload)
                          && low_shadow == $past(low_phase_reload) && irq_stat;
    endproperty
    a_cycle_reload: assert property (p_cycle_reload) else $error("cycle end reload missed");

    property p_hold_zero;
        @(posedge mclk) disable iff (!nrst)
            (active && started && intv_zero && !cycle_end) |=> intv_zero;
    endproperty
    a_hold_zero: assert property (p_hold_zero) else $error("interval left zero early");

    property p_disabled;
        @(posedge mclk) disable iff (!nrst)
            !active |=> pulse_cnt == '0 && !pulse_out_true && !started;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled timer not held");

    property p_freeze;
        @(posedge mclk) disable iff (!nrst)
            (freeze_request && active && started) |=> $stable(pulse_cnt) && $stable(intv_cnt);
    endproperty
    a_freeze: assert property (p_freeze) else $error("counters moved while frozen");

    property p_read_intv;
        @(posedge mclk) disable iff (!nrst)
            (rd && addr == dpt_pkg::ADDR_INTV) |=> rdata == $past(intv_cnt);
    endproperty
    a_read_intv: assert property (p_read_intv) else $error("interval read not live");

    property p_read_pulse;
        @(posedge mclk) disable iff (!nrst)
            (rd && (addr == dpt_pkg::ADDR_HIGH || addr == dpt_pkg::ADDR_LOW)) |=> rdata == $past(pulse_cnt);
    endproperty
    a_read_pulse: assert property (p_read_pulse) else $error("phase read not live");

    property p_rdata_idle;
        @(posedge mclk) disable iff (!nrst)
            !rd |=> rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

    property p_start_irq;
        @(posedge mclk) disable iff (!nrst)
            start_evt |=> irq_stat;
    endproperty
    a_start_irq: assert property (p_start_irq) else $error("start did not set status");

    property p_irq_on;
        @(posedge mclk) disable iff (!nrst)
            (irq_stat && irq_mask) |=> tick_interrupt;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("unmasked status without irq");

    property p_irq_off;
        @(posedge mclk) disable iff (!nrst)
            !irq_mask |=> !tick_interrupt;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("masked irq raised");

    property p_out_high;
        @(posedge mclk) disable iff (!nrst)
            (active && started && phase == dpt_pkg::DPT_PH_HIGH && !cfg.clkout) |=> pulse_out_true;
    endproperty
    a_out_high: assert property (p_out_high) else $error("output low in high phase");

    property p_out_low;
        @(posedge mclk) disable iff (!nrst)
            (active && phase == dpt_pkg::DPT_PH_LOW) |=> !pulse_out_true;
    endproperty
    a_out_low: assert property (p_out_low) else $error("output high in low phase");

    property p_gate_off;
        @(posedge mclk) disable iff (!nrst)
            (active && cfg.src_fast && !cfg.gate) |=> !tick;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("tick with fast clock gated");
endmodule // dpt_timer

// ---- tb.sv ----
// testbench for the dual phase pwm timer: register tasks and a scenario list
// assumes dpt_timer with its plain register port and a 20 MHz mclk
`timescale 1ns/100ps
`define CHECK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb;
    logic mclk;
    logic nrst;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic pulse_out_true;
    logic pulse_out_inverted;
    logic tick_interrupt;
    logic [15:0] v;
    logic [15:0] w;
    logic p;
    int errors = 0;
    int n_compared = 0;
    int hi;
    int lo;
    int n;

    dpt_timer dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .pulse_out_true(pulse_out_true),
        .pulse_out_inverted(pulse_out_inverted), .tick_interrupt(tick_interrupt));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ==========================================================
    // closing report
    task automatic end_sim();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // bus tasks; one idle cycle after each strobe keeps drives single
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        d = rdata;
    endtask

    task automatic cycles(input int k);
        repeat (k) @(posedge mclk);
    endtask

    task automatic restart(input logic [15:0] c);
        wr_reg(dpt_pkg::ADDR_CTRL, 16'h0000);
        wr_reg(dpt_pkg::ADDR_CTRL, c);
    endtask

    task automatic wait_lvl(input logic lvl, input int lim, output int k);
        k = 0;
        while (pulse_out_true !== lvl) begin
            @(posedge mclk);
            k++;
            if (k > lim) begin
                errors++;
                $display("wrong value pulse_wait expected %h seen %h", lvl, pulse_out_true);
                end_sim();
            end
        end
    endtask

    // skips the phase in progress so both lengths are whole phases
    task automatic measure(input int lim);
        wait_lvl(1'b0, lim, n);
        wait_lvl(1'b1, lim, n);
        wait_lvl(1'b0, lim, hi);
        wait_lvl(1'b1, lim, lo);
    endtask

    // tick rates are averaged, so lengths are matched to two cycles
    function automatic int exp_cyc(input int h, input int dv);
        return (h + 1) * dpt_pkg::MCLK_HZ / (dpt_pkg::FAST_BASE_HZ >> dv);
    endfunction

    function automatic logic near(input int a, input int b);
        return (a - b <= 2) && (b - a <= 2);
    endfunction

    always @(negedge mclk) begin
        `CHECK("pulse_out_inverted", ~pulse_out_true, pulse_out_inverted)
    end

    initial begin
        #(50 * 90000);
        errors++;
        $display("wrong value run_time expected %h seen %h", 1'b0, 1'b1);
        end_sim();
    end

    // ==========================================================
    // scenarios
    initial begin
        nrst = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rd_reg(dpt_pkg::ADDR_HIGH, v);
        `CHECK("high_reset", dpt_pkg::RESET_VALUE, v)
        rd_reg(dpt_pkg::ADDR_LOW, v);
        `CHECK("low_reset", dpt_pkg::RESET_VALUE, v)
        rd_reg(dpt_pkg::ADDR_INTV, v);
        `CHECK("interval_reset", dpt_pkg::RESET_VALUE, v)
        rd_reg(4'hF, v);
        `CHECK("unmapped", 16'h0000, v)
        `CHECK("irq_reset", 1'b0, tick_interrupt)
        wr_reg(dpt_pkg::ADDR_CLKCFG, 16'h0001);
        wr_reg(dpt_pkg::ADDR_HIGH, 16'h0007);
        wr_reg(dpt_pkg::ADDR_LOW, 16'h0003);
        wr_reg(dpt_pkg::ADDR_INTV, 16'h0FFF);
        wr_reg(dpt_pkg::ADDR_IRQ_MASK, 16'h0000);
        wr_reg(dpt_pkg::ADDR_CTRL, 16'h0003);
        cycles(6);
        `CHECK("irq_masked", 1'b0, tick_interrupt)
        rd_reg(dpt_pkg::ADDR_IRQ_STAT, v);
        `CHECK("irq_status", 1'b1, v[0])
        wr_reg(dpt_pkg::ADDR_IRQ_MASK, 16'h0001);
        cycles(2);
        `CHECK("irq_unmasked", 1'b1, tick_interrupt)
        wr_reg(dpt_pkg::ADDR_IRQ_STAT, 16'h0001);
        cycles(2);
        `CHECK("irq_cleared", 1'b0, tick_interrupt)
        rd_reg(dpt_pkg::ADDR_INTV, v);
        `CHECK("interval_live", 1'b1, (v < 16'h0FFF) && (v != 16'h0000))
        rd_reg(dpt_pkg::ADDR_HIGH, v);
        `CHECK("pulse_live", 1'b1, v <= 16'h0007)
        measure(100);
        `CHECK("high_len", 1'b1, near(hi, exp_cyc(7, 0)))
        `CHECK("low_len", 1'b1, near(lo, exp_cyc(3, 0)))
        // interval still far from zero, so the new value must wait
        wr_reg(dpt_pkg::ADDR_HIGH, 16'h0014);
        measure(100);
        `CHECK("high_kept", 1'b1, near(hi, exp_cyc(7, 0)))
        wr_reg(dpt_pkg::ADDR_FRZ_SET, 16'h0001);
        rd_reg(dpt_pkg::ADDR_INTV, v);
        cycles(20);
        rd_reg(dpt_pkg::ADDR_INTV, w);
        `CHECK("frozen", v, w)
        rd_reg(dpt_pkg::ADDR_FRZ_SET, w);
        `CHECK("freeze_state", 1'b1, w[0])
        wr_reg(dpt_pkg::ADDR_FRZ_CLR, 16'h0001);
        cycles(20);
        rd_reg(dpt_pkg::ADDR_INTV, w);
        `CHECK("resumed", 1'b1, w < v)
        wr_reg(dpt_pkg::ADDR_CTRL, 16'h0000);
        cycles(2);
        `CHECK("off_pulse", 1'b0, pulse_out_true)
        rd_reg(dpt_pkg::ADDR_HIGH, v);
        `CHECK("off_pulse_cnt", 16'h0000, v)
        rd_reg(dpt_pkg::ADDR_STATUS, v);
        `CHECK("off_status", 16'h0001, v)
        // long interval keeps the irq rate low on fast clocks
        wr_reg(dpt_pkg::ADDR_INTV, 16'h0FFF);
        wr_reg(dpt_pkg::ADDR_CTRL, 16'h0003);
        for (int dv = 0; dv < 4; dv++) begin
            wr_reg(dpt_pkg::ADDR_CLKCFG, 16'(2 * dv + 1));
            measure(500);
            `CHECK("fast_high_len", 1'b1, near(hi, exp_cyc(20, dv)))
        end
        restart(16'h000B);
        n = 0;
        p = pulse_out_true;
        repeat (400) begin
            @(posedge mclk);
            if (pulse_out_true !== p) n++;
            p = pulse_out_true;
        end
        `CHECK("clkout_edges", 1'b1, n > 8)
        wr_reg(dpt_pkg::ADDR_HIGH, 16'h0000);
        wr_reg(dpt_pkg::ADDR_LOW, 16'h0000);
        restart(16'h0001);
        measure(2000);
        `CHECK("slow_high_len", 1'b1, near(hi, dpt_pkg::MCLK_HZ / dpt_pkg::SLOW_HZ))
        // fast source with the gate shut gives no ticks at all
        wr_reg(dpt_pkg::ADDR_CLKCFG, 16'h0000);
        restart(16'h0003);
        cycles(4);
        n = 0;
        repeat (100) begin
            @(posedge mclk);
            n = n + (pulse_out_true === 1'b1 ? 1 : 0);
        end
        `CHECK("gate_off_hold", 100, n)
        wr_reg(dpt_pkg::ADDR_CLKCFG, 16'h0001);
        wr_reg(dpt_pkg::ADDR_HIGH, 16'h0028);
        wr_reg(dpt_pkg::ADDR_LOW, 16'h0028);
        wr_reg(dpt_pkg::ADDR_INTV, 16'h0004);
        restart(16'h0003);
        cycles(20);
        rd_reg(dpt_pkg::ADDR_INTV, v);
        `CHECK("interval_hold", 16'h0000, v)
        restart(16'h0007);
        cycles(20);
        rd_reg(dpt_pkg::ADDR_INTV, v);
        `CHECK("interval_slowed", 1'b1, v >= 16'h0002)
        measure(200);
        `CHECK("presc_high_len", 1'b1, near(hi, exp_cyc(40, 0)))
        // mid-run reset: reloads must come back as zero, so one slow tick a phase
        nrst <= 1'b0;
        cycles(2);
        `CHECK("reset_pulse", 1'b0, pulse_out_true)
        nrst <= 1'b1;
        @(posedge mclk);
        wr_reg(dpt_pkg::ADDR_CTRL, 16'h0001);
        measure(2000);
        `CHECK("reset_high_len", 1'b1, near(hi, dpt_pkg::MCLK_HZ / dpt_pkg::SLOW_HZ))
        end_sim();
    end
endmodule // tb
